// ===== pkg/exlp_pkg.sv
// exlp_pkg: constants and types for the exception and low-power control block
package exlp_pkg;
	// register indices (no offsets printed; index = byte address for this plain port)
	localparam logic [3:0] REG_PEND_FIRST = 4'h0;
	localparam logic [3:0] REG_PEND_SECOND = 4'h1;
	localparam logic [3:0] REG_PEND_THIRD = 4'h2;
	localparam logic [3:0] REG_BREAK_STATUS = 4'h3;
	localparam logic [3:0] REG_BREAK_FLAG_CTRL = 4'h4;
	localparam logic [3:0] REG_CONFIG_ONE = 4'h5;
	localparam logic [3:0] REG_MODE_STATUS = 4'h6;
	// field positions
	localparam int BWE_BIT = 1;
	localparam int BREAK_CLEAR_ENABLE_BIT = 0;
	localparam int CFG_WDOG_DIS_BIT = 0;
	localparam int CFG_SHORT_REC_BIT = 1;
	localparam int CFG_STOP_EN_BIT = 2;
	// reset values
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] BFC_RESET = 8'h00;
	// recovery counts in crystal cycles
	localparam int REC_LONG = 4096;
	localparam int REC_SHORT = 32;
	localparam int NUM_SRC = 16;
	// vector codes: 0 reset, 1 software trap, 2..17 sources 1..16
	localparam logic [4:0] VEC_RESET = 5'h00;
	localparam logic [4:0] VEC_SWTRAP = 5'h01;
	localparam logic [4:0] VEC_SRC_BASE = 5'h02;

	typedef enum logic [2:0] {
		EXLP_RUN = 3'b000,
		EXLP_WAIT = 3'b001,
		EXLP_STOP = 3'b010,
		EXLP_RECOVER = 3'b011,
		EXLP_STACK = 3'b100
	} exlp_state_t;

	// core handshake towards the block
	typedef struct packed {
		logic instr_done;
		logic swtrap_exec;
		logic wait_exec;
		logic stop_exec;
		logic rti_exec;
		logic stack_done;
		logic i_mask;
	} exlp_core_req_t;
endpackage

// ===== verilog/exlp_ctrl.sv
// exlp_ctrl: interrupt latch and arbitration, break flag protection, wait/stop sequencing
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Function
// - entry stacks registers and sets mask
// - latch requests, arbitrate, give vector code
// - latched request held until serviced or unmasked
// - hardware requests checked after instruction end
// - take only if unmasked and enabled
// - highest pending priority served first
// - fixed priority reset, trap, sources 1-16
// - software trap ignores global mask
// - trap stacks pc, hardware stacks pc-1
// - first flags: sources 1-6, bits 1:0 zero
// - second flags: sources 14 down to 7
// - third flags: sources 16,15 low bits
// - reset outranks all, never arbitrated
// - break forces software trap vector
// - break protects flags unless clear enabled
// - two-step clears stay protected in break; code allows them in break once clear enable is set
// - wait and stop clear global mask
// - wait stops core clock, wakes on interrupt
// - break leaving wait sets wait-exit flag
// - watchdog runs in wait unless disabled
// - stop gates clocks, recovery counter held
// - stop recovery 4096 or 32 cycles
// - wait-exit flag shows break-wait exit
// - clear enable bit is read/write
module exlp_ctrl import exlp_pkg::*; #(
	parameter int REC_LONG_CYC = REC_LONG
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NUM_SRC-1:0] irq_req,
	input wire logic [NUM_SRC-1:0] irq_en,
	input wire logic break_req,
	input wire exlp_core_req_t core,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic take_int,
	output logic [4:0] vec_code,
	output logic stack_pc_minus1,
	output logic set_i_mask,
	output logic clr_i_mask,
	output logic core_clk_en,
	output logic periph_clk_en,
	output logic xtal_clk_en,
	output logic watchdog_run,
	output logic flag_clear_allow,
	output logic in_break
);
	// break request is a pin-side level: two flops before use
	logic brk_s1_ff, brk_s2_ff;
	exlp_state_t state_ff, nxt_state;
	logic latched_ff, nxt_latched;
	logic [4:0] lvec_ff, nxt_lvec;
	logic [12:0] rec_cnt_ff, nxt_rec_cnt;
	logic bwe_ff, break_clear_enable_ff;
	logic [7:0] cfg_ff;
	logic take_ff, pcm1_ff, seti_ff, clri_ff, brk_ff, allow_ff;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [NUM_SRC-1:0] pend_ff;

	// priority encoder: lowest index is highest priority
	function automatic logic [4:0] prio_vec(input logic [NUM_SRC-1:0] req);
		logic [4:0] v;
		v = VEC_SRC_BASE;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = VEC_SRC_BASE + 5'(i);
			end
		end
		return v;
	endfunction

	// decode and qualification
	wire brk_now = brk_s2_ff;
	wire [NUM_SRC-1:0] hw_ok = pend_ff & irq_en;
	wire hw_any = (|hw_ok) & ~core.i_mask;
	wire run_pick = (state_ff == EXLP_RUN) & core.instr_done;
	wire sw_pick = run_pick & (core.swtrap_exec | brk_now);
	wire hw_pick = run_pick & ~sw_pick & hw_any & ~latched_ff;
	wire wake_any = (|hw_ok) | brk_now; // mask cleared by the low-power instruction
	wire short_rec = cfg_ff[CFG_SHORT_REC_BIT];
	wire [12:0] rec_target = short_rec ? 13'(REC_SHORT) : 13'(REC_LONG_CYC);
	wire wr_bfc = reg_wr & (reg_addr == REG_BREAK_FLAG_CTRL);
	wire wr_cfg = reg_wr & (reg_addr == REG_CONFIG_ONE);
	wire wr_bsr = reg_wr & (reg_addr == REG_BREAK_STATUS);
	wire bwe_set = (state_ff == EXLP_WAIT) & brk_now;

	// sequencing of run, wait, stop and recovery
	always_comb begin
		nxt_state = state_ff;
		nxt_latched = latched_ff;
		nxt_lvec = lvec_ff;
		nxt_rec_cnt = rec_cnt_ff;
		case (state_ff)
			EXLP_RUN: begin
				if (sw_pick) begin
					nxt_latched = 1'b1;
					nxt_lvec = VEC_SWTRAP;
					nxt_state = EXLP_STACK;
				end else if (hw_pick) begin
					nxt_latched = 1'b1;
					nxt_lvec = prio_vec(hw_ok);
					nxt_state = EXLP_STACK;
				end else if (core.wait_exec) begin
					nxt_state = EXLP_WAIT;
				end else if (core.stop_exec & cfg_ff[CFG_STOP_EN_BIT]) begin
					nxt_rec_cnt = 13'h0000;
					nxt_state = EXLP_STOP;
				end
			end
			EXLP_WAIT: begin
				// stacking begins the cycle after the wake event
				if (wake_any) begin
					nxt_latched = 1'b1;
					nxt_lvec = brk_now ? VEC_SWTRAP : prio_vec(hw_ok);
					nxt_state = EXLP_STACK;
				end
			end
			EXLP_STOP: begin
				nxt_rec_cnt = 13'h0000;
				if (wake_any) begin
					nxt_state = EXLP_RECOVER;
				end
			end
			EXLP_RECOVER: begin
				nxt_rec_cnt = rec_cnt_ff + 13'h0001;
				if (nxt_rec_cnt >= rec_target) begin
					nxt_latched = 1'b1;
					nxt_lvec = brk_now ? VEC_SWTRAP : prio_vec(hw_ok);
					nxt_state = EXLP_STACK;
				end
			end
			EXLP_STACK: begin
				// core stacks and sets the mask; wait for it
				if (core.stack_done) begin
					nxt_state = EXLP_RUN;
				end
			end
			default: begin
				nxt_state = EXLP_RUN;
			end
		endcase
		// serviced (return) or mask cleared drops the latch
		if (latched_ff & (core.rti_exec | ~core.i_mask) & (state_ff == EXLP_RUN)) begin
			nxt_latched = 1'b0;
		end
	end

	// read mux; pending registers have no write path
	always_comb begin
		nxt_rdata = 8'h00;
		case (reg_addr)
			REG_PEND_FIRST: nxt_rdata = {pend_ff[5:0], 2'b00};
			REG_PEND_SECOND: nxt_rdata = {pend_ff[13], pend_ff[12], pend_ff[11],
				pend_ff[10], pend_ff[9], pend_ff[8], pend_ff[7], pend_ff[6]};
			REG_PEND_THIRD: nxt_rdata = {6'h00, pend_ff[15], pend_ff[14]};
			REG_BREAK_STATUS: nxt_rdata = 8'(bwe_ff) << BWE_BIT;
			REG_BREAK_FLAG_CTRL: nxt_rdata = 8'(break_clear_enable_ff) << BREAK_CLEAR_ENABLE_BIT;
			REG_CONFIG_ONE: nxt_rdata = cfg_ff;
			REG_MODE_STATUS: nxt_rdata = {3'h0, latched_ff, 1'b0, state_ff};
			default: nxt_rdata = 8'h00;
		endcase
	end

	// synchroniser and request latch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			brk_s1_ff <= 1'b0;
			brk_s2_ff <= 1'b0;
			pend_ff <= '0;
		end else begin
			brk_s1_ff <= break_req;
			brk_s2_ff <= brk_s1_ff;
			pend_ff <= irq_req;
		end
	end

	// state, latch and recovery counter; async reset outranks all
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= EXLP_RUN;
			latched_ff <= 1'b0;
			lvec_ff <= VEC_RESET;
			rec_cnt_ff <= 13'h0000;
		end else begin
			state_ff <= nxt_state;
			latched_ff <= nxt_latched;
			lvec_ff <= nxt_lvec;
			rec_cnt_ff <= nxt_rec_cnt;
		end
	end

	// software registers; a set of the wait-exit flag beats a clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bwe_ff <= 1'b0;
			break_clear_enable_ff <= BFC_RESET[BREAK_CLEAR_ENABLE_BIT];
			cfg_ff <= CFG_RESET;
			rdata_ff <= 8'h00;
		end else begin
			if (bwe_set) begin
				bwe_ff <= 1'b1;
			end else if (wr_bsr & ~reg_wdata[BWE_BIT]) begin
				bwe_ff <= 1'b0;
			end
			if (wr_bfc) begin
				break_clear_enable_ff <= reg_wdata[BREAK_CLEAR_ENABLE_BIT];
			end
			if (wr_cfg) begin
				cfg_ff <= reg_wdata;
			end
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	// registered outputs to the core and break flags; clock gates decode state_ff directly
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			take_ff <= 1'b0;
			pcm1_ff <= 1'b0;
			seti_ff <= 1'b0;
			clri_ff <= 1'b0;
			brk_ff <= 1'b0;
			allow_ff <= 1'b1;
		end else begin
			take_ff <= (nxt_state == EXLP_STACK) & (state_ff != EXLP_STACK);
			pcm1_ff <= (state_ff != EXLP_STACK) & (nxt_state == EXLP_STACK) &
				(nxt_lvec != VEC_SWTRAP);
			seti_ff <= (nxt_state == EXLP_STACK) & (state_ff != EXLP_STACK);
			clri_ff <= run_pick & ~sw_pick & ~hw_pick &
				(core.wait_exec | core.stop_exec);
			brk_ff <= brk_now;
			// two-step clears get no hold-off of their own; the allow is withheld in break only while clear enable is 0
			allow_ff <= ~brk_now | (wr_bfc ? reg_wdata[BREAK_CLEAR_ENABLE_BIT] : break_clear_enable_ff);
		end
	end

	assign flag_clear_allow = allow_ff;
	assign in_break = brk_ff;
	assign reg_rdata = rdata_ff;
	assign take_int = take_ff;
	assign vec_code = lvec_ff;
	assign stack_pc_minus1 = pcm1_ff;
	assign set_i_mask = seti_ff;
	assign clr_i_mask = clri_ff;
	assign core_clk_en = (state_ff == EXLP_RUN) | (state_ff == EXLP_STACK);
	assign periph_clk_en = (state_ff != EXLP_STOP) & (state_ff != EXLP_RECOVER);
	assign xtal_clk_en = (state_ff != EXLP_STOP);
	assign watchdog_run = ~cfg_ff[CFG_WDOG_DIS_BIT] & (state_ff != EXLP_STOP);
endmodule
`default_nettype wire

// ===== test/exlp_core_model.sv
// exlp_core_model: core stand-in that ends instructions and stacks on entry
`timescale 1ns/10ps
`default_nettype none
module exlp_core_model import exlp_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic take_int,
	input wire logic set_i_mask,
	input wire logic clr_i_mask,
	input wire logic core_clk_en,
	input wire logic [3:0] op,
	input wire logic [3:0] stk_len,
	output var exlp_core_req_t core
);
	int stk;
	logic ph;
	// op {trap,wait,stop,rti} ends an instruction; stacking lasts stk_len cycles, prompt or slow
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core <= '0;
			stk <= 0;
			ph <= 1'b0;
		end else begin
			ph <= ~ph;
			core.instr_done <= core_clk_en && stk == 0 && (ph || op != 4'h0);
			{core.swtrap_exec, core.wait_exec, core.stop_exec, core.rti_exec} <= op;
			core.stack_done <= stk == 1;
			stk <= take_int ? int'(stk_len) : (stk > 0 ? stk - 1 : 0);
			if (set_i_mask)
				core.i_mask <= 1'b1;
			else if (clr_i_mask || op[0])
				core.i_mask <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== test/exlp_ctrl_asserts.sv
// exlp_ctrl_asserts: port checks for the exception control block
`timescale 1ns/10ps
`default_nettype none
module exlp_ctrl_asserts import exlp_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NUM_SRC-1:0] irq_req,
	input wire exlp_core_req_t core,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic take_int,
	input wire logic [4:0] vec_code,
	input wire logic stack_pc_minus1,
	input wire logic set_i_mask,
	input wire logic clr_i_mask,
	input wire logic core_clk_en,
	input wire logic periph_clk_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// a wait only counts when issued with the core clock still on (run or stacking)
	sequence s_wait; core.wait_exec && core_clk_en; endsequence
	sequence s_rd(logic [3:0] a); reg_rd && reg_addr == a; endsequence
	property p_mask; take_int |-> set_i_mask; endproperty
	a_mask: assert property (p_mask) else $error("entry without mask");
	property p_hw_pc; take_int && vec_code >= VEC_SRC_BASE |-> stack_pc_minus1; endproperty
	a_hw_pc: assert property (p_hw_pc) else $error("hw entry pc");
	property p_trap_pc; take_int && vec_code == VEC_SWTRAP |-> !stack_pc_minus1; endproperty
	a_trap_pc: assert property (p_trap_pc) else $error("trap entry pc");
	// flags lag the requests one cycle, read data one more
	property p_first; s_rd(REG_PEND_FIRST) |=> reg_rdata == {$past(irq_req[5:0], 2), 2'b00};
	endproperty
	a_first: assert property (p_first) else $error("first flags");
	property p_second; s_rd(REG_PEND_SECOND) |=> reg_rdata == $past(irq_req[13:6], 2); endproperty
	a_second: assert property (p_second) else $error("second flags");
	property p_third; s_rd(REG_PEND_THIRD) |=> reg_rdata == {6'h00, $past(irq_req[15:14], 2)};
	endproperty
	a_third: assert property (p_third) else $error("third flags");
	property p_wait_clr; s_wait |=> clr_i_mask; endproperty
	a_wait_clr: assert property (p_wait_clr) else $error("wait mask");
	property p_wait_clk; s_wait |=> !core_clk_en && periph_clk_en; endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("wait clocks");
endmodule
bind exlp_ctrl exlp_ctrl_asserts u_asserts (.clk, .arst_n, .irq_req, .core, .reg_addr, .reg_rd,
	.reg_rdata, .take_int, .vec_code, .stack_pc_minus1, .set_i_mask, .clr_i_mask, .core_clk_en,
	.periph_clk_en);
`default_nettype wire

// ===== test/testbench.sv
// testbench: self-checking bench for the exception and low-power control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench import exlp_pkg::*;;
	localparam int REC_L = 16;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] irq_req = '0;
	logic [15:0] irq_en = '0;
	logic break_req = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] op = 4'h0;
	logic [3:0] stk_len = 4'h1;
	exlp_core_req_t core;
	logic [7:0] reg_rdata, d;
	logic [4:0] vec_code;
	logic take_int, stack_pc_minus1, set_i_mask, clr_i_mask, core_clk_en, periph_clk_en;
	logic xtal_clk_en, watchdog_run, flag_clear_allow, in_break;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int takes = 0;
	int n, b;
	exlp_ctrl #(.REC_LONG_CYC(REC_L)) u_dut (.clk, .arst_n, .irq_req, .irq_en, .break_req, .core,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .take_int, .vec_code, .stack_pc_minus1,
		.set_i_mask, .clr_i_mask, .core_clk_en, .periph_clk_en, .xtal_clk_en, .watchdog_run,
		.flag_clear_allow, .in_break);
	exlp_core_model u_core (.clk, .arst_n, .take_int, .set_i_mask, .clr_i_mask, .core_clk_en, .op,
		.stk_len, .core);
	initial forever #2 clk = ~clk;
	// cycle ceiling well above the longest recovery; also counts entries
	always @(posedge clk) begin
		cyc++;
		if (take_int === 1'b1) takes++;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk) d = reg_rdata;
	endtask
	task automatic do_op(input logic [3:0] v);
		@(posedge clk);
		op <= v;
		@(posedge clk);
		op <= 4'h0;
		repeat (2) @(negedge clk);
	endtask
	task automatic wait_take();
		n = 0;
		while (take_int !== 1'b1 && n < 9000) begin
			@(negedge clk);
			n++;
		end
		`CHK("take", 1'b1, take_int)
	endtask
	// reference pick: lowest source number among enabled requests wins
	function automatic logic [4:0] exp_vec(logic [15:0] r, logic [15:0] e);
		for (int i = 0; i < 16; i++) if (r[i] && e[i]) return 5'(2 + i);
		return 5'h1f;
	endfunction
	task automatic isr(input logic [15:0] r, input logic [15:0] e);
		@(posedge clk);
		{irq_req, irq_en, takes} <= {r, e, 32'd0};
		wait_take();
		`CHK("vec", exp_vec(r, e), vec_code)
		`CHK("pcm1", 1'b1, stack_pc_minus1)
	endtask
	// hold the source through the handler; a masked core must not re-enter
	task automatic leave(input logic trap);
		repeat (20) @(posedge clk);
		`CHK("held", 1, takes)
		if (trap) begin
			do_op(4'h8);
			wait_take();
			`CHK("trap_vec", VEC_SWTRAP, vec_code)
			`CHK("trap_pc", 1'b0, stack_pc_minus1)
			repeat (12) @(posedge clk);
		end
		irq_req <= '0;
		do_op(4'h1);
	endtask
	initial begin
		void'($urandom(72));
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		`CHK("rst_vec", VEC_RESET, vec_code)
		`CHK("rst_clk", 4'hf, {core_clk_en, periph_clk_en, xtal_clk_en, watchdog_run})
		// flags follow requests; writes to the flag registers do nothing
		for (int k = 0; k < 4; k++) begin
			irq_req <= 16'($urandom());
			for (int j = 0; j < 3; j++) wr(4'(j), 8'($urandom()));
			rd(REG_PEND_FIRST);
			`CHK("pend1", {irq_req[5:0], 2'b00}, d)
			rd(REG_PEND_SECOND);
			`CHK("pend2", irq_req[13:6], d)
			rd(REG_PEND_THIRD);
			`CHK("pend3", {6'h00, irq_req[15:14]}, d)
		end
		rd(4'hf);
		`CHK("unmapped", 8'h00, d)
		irq_req <= '0;
		repeat (2) @(posedge clk);
		`CHK("no_take", 0, takes)
		for (int k = 0; k < 8; k++) begin
			b = $urandom_range(15);
			stk_len <= 4'($urandom_range(8, 1));
			isr(16'($urandom()) | 16'(1 << b), 16'($urandom()) | 16'(1 << b));
			leave(k[0]);
		end
		do_op(4'h4);
		`CHK("wait_clk", 3'b011, {core_clk_en, periph_clk_en, watchdog_run})
		isr(16'h0300, 16'h0200);
		leave(1'b0);
		// stop with short then long recovery
		for (int k = 0; k < 2; k++) begin
			wr(REG_CONFIG_ONE, k ? 8'h04 : 8'h06);
			do_op(4'h2);
			`CHK("stop_clk", 2'b00, {core_clk_en, xtal_clk_en})
			isr(16'h8000, 16'h8000);
			`CHK("rec", 1'b1, n >= (k ? REC_L : REC_SHORT) && n < (k ? REC_L : REC_SHORT) + 8)
			leave(1'b0);
		end
		// break out of wait: trap vector, wait-exit flag, flag protection
		do_op(4'h4);
		break_req <= 1'b1;
		wait_take();
		`CHK("brk", {VEC_SWTRAP, 2'b10}, {vec_code, in_break, flag_clear_allow})
		rd(REG_BREAK_STATUS);
		`CHK("bwe", 1'b1, d[BWE_BIT])
		wr(REG_BREAK_FLAG_CTRL, 8'h01);
		rd(REG_BREAK_FLAG_CTRL);
		`CHK("break_clear_enable", 2'b11, {d[BREAK_CLEAR_ENABLE_BIT], flag_clear_allow})
		break_req <= 1'b0;
		do_op(4'h1);
		test_done();
	end
endmodule
`default_nettype wire
